//--- hdl/sirq_defs.svh
// sirq_defs.svh: constants shared by both ends of the serial irq link
// assumes: included by bare name from both end modules and the testbench
`ifndef SIRQ_DEFS_SVH
`define SIRQ_DEFS_SVH

// ----------------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------------
`define SIRQ_FRAMES      32
`define SIRQ_FRAME_W     5
`define SIRQ_LAST_FRAME  5'h1F
`define SIRQ_RUN_W       4
`define SIRQ_RUN_MAX     4'hF

// ----------------------------------------------------------------------
// start and stop pulse lengths in clocks
// ----------------------------------------------------------------------
`define SIRQ_START_MIN   4'h4
`define SIRQ_START_MAX   4'h8
`define SIRQ_STOP_QUIET  4'h2
`define SIRQ_STOP_CONT   4'h3

// ----------------------------------------------------------------------
// slot index of each device source (frame 1 is index 0)
// ----------------------------------------------------------------------
`define SIRQ_SLOT_KBD    1
`define SIRQ_SLOT_SMI    2
`define SIRQ_SLOT_UARTB  3
`define SIRQ_SLOT_UARTA  4
`define SIRQ_SLOT_FDC    6
`define SIRQ_SLOT_LPT    7
`define SIRQ_SLOT_MOUSE  12

`endif

//--- hdl/sirq_pkg.sv
// sirq_pkg.sv: state and phase types of the serial irq link
// assumes: sirq_defs.svh on the include path
package sirq_pkg;

  // ----------------------------------------------------------------------
  // frame phase, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SIRQ_PH_S = 3'h1,
    SIRQ_PH_R = 3'h2,
    SIRQ_PH_T = 3'h4
  } sirq_phase_e;

  // ----------------------------------------------------------------------
  // device end states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    SIRQ_D_IDLE   = 5'h01,
    SIRQ_D_QSTART = 5'h02,
    SIRQ_D_LEAD   = 5'h04,
    SIRQ_D_FRAME  = 5'h08,
    SIRQ_D_TAIL   = 5'h10
  } sirq_dev_state_e;

  // ----------------------------------------------------------------------
  // host end states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [7:0] {
    SIRQ_H_IDLE  = 8'h01,
    SIRQ_H_START = 8'h02,
    SIRQ_H_SREC  = 8'h04,
    SIRQ_H_STA   = 8'h08,
    SIRQ_H_FRAME = 8'h10,
    SIRQ_H_STOP  = 8'h20,
    SIRQ_H_PREC  = 8'h40,
    SIRQ_H_PTA   = 8'h80
  } sirq_host_state_e;

endpackage

//--- hdl/sirq_if.sv
// sirq_if.sv: the shared open-drain serial irq line between two ends
// assumes: both ends run on the same pci clock; line idles high (pull-up)
`timescale 1ns/100ps
interface sirq_if;

  // ----------------------------------------------------------------------
  // per-end drive value and enable, resolved line level
  // ----------------------------------------------------------------------
  logic dev_drv;
  logic dev_oe;
  logic host_drv;
  logic host_oe;
  logic line;

  // any enabled low wins; otherwise driven high or pulled up
  assign line = ~((dev_oe & ~dev_drv) | (host_oe & ~host_drv));

  modport dev (
    input  line,
    output dev_drv,
    output dev_oe
  );

  modport host (
    input  line,
    output host_drv,
    output host_oe
  );

endinterface

//--- hdl/sirq_dev.sv
// sirq_dev.sv: device end of the serial irq link (slave frame driver)
// assumes: line and request inputs are on clk_i (pci clock), line has
// a pull-up, the host end produces start and stop frames
//
// Behaviour
// [R01] frame count starts at start pulse rising edge
// [R02] each frame: sample, recovery, turnaround clock
// [R03] sample clock: pull low when slot pending
// [R04] recovery clock: drive high after signalling
// [R05] turnaround clock: release the line
// [R06] driving starts at irq0 frame, rising edges
// [R07] fixed slot order, smi in frame three
// [R08] frames 17-21 pci lines, 22-32 unassigned
// [R09] device sources mapped to their fixed slots
// [R10] host ends each cycle with stop frame
// [R11] only host drives stop, 2 or 3 clocks; device still drives its next pending slot if the host stops before frame 32
// [R12] stop length 2 quiet, 3 continuous
// [R13] idle clocks around stop keep synchronisation
// [R14] wait for next start, no fixed gap
// [R15] quiet: device may pull start one clock
// [R16] continuous after reset, host-only start
// [R17] open drain: low, brief high, or release
// [R18] all timing counted in pci clocks
// [R19] quiet start only idle and changed request
`timescale 1ns/100ps
`include "sirq_defs.svh"

module sirq_dev
  import sirq_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  sirq_if.dev       sirq,
  input  wire logic kbd_irq_i,
  input  wire logic hwm_irq_i,
  input  wire logic smi_req_i,
  input  wire logic uartb_irq_i,
  input  wire logic uarta_irq_i,
  input  wire logic fdc_irq_i,
  input  wire logic lpt_irq_i,
  input  wire logic mouse_irq_i,
  output logic      quiet_mode_o,
  output logic      frame_busy_o
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  sirq_dev_state_e           state_reg;
  sirq_dev_state_e           state_next;
  sirq_phase_e               phase_reg;
  sirq_phase_e               phase_next;
  logic [`SIRQ_FRAME_W-1:0]  frame_reg;
  logic [`SIRQ_FRAME_W-1:0]  frame_next;
  logic [`SIRQ_RUN_W-1:0]    low_run_reg;
  logic [`SIRQ_FRAMES-1:0]   pending;
  logic [`SIRQ_FRAMES-1:0]   reported_reg;
  logic                      quiet_reg;
  logic                      oe_reg;
  logic                      drv_reg;
  logic                      oe_next;
  logic                      drv_next;
  logic                      run_end;
  logic                      start_seen;
  logic                      stop_seen;
  logic                      qstart_ok;

  // ----------------------------------------------------------------------
  // slot map of the device sources
  // ----------------------------------------------------------------------
  // one bit per frame; unused slots never assert
  always_comb begin
    pending                   = '0;
    pending[`SIRQ_SLOT_KBD]   = kbd_irq_i;                // [R09]
    pending[`SIRQ_SLOT_SMI]   = hwm_irq_i | smi_req_i;    // [R07] [R09]
    pending[`SIRQ_SLOT_UARTB] = uartb_irq_i;              // [R09]
    pending[`SIRQ_SLOT_UARTA] = uarta_irq_i;              // [R09]
    pending[`SIRQ_SLOT_FDC]   = fdc_irq_i;                // [R09]
    pending[`SIRQ_SLOT_LPT]   = lpt_irq_i;                // [R09]
    pending[`SIRQ_SLOT_MOUSE] = mouse_irq_i;              // [R09]
  end

  // ----------------------------------------------------------------------
  // low-run decoder on the shared line
  // ----------------------------------------------------------------------
  // counts consecutive low clocks, saturating; a rising edge ends a run
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_run_reg <= '0;
    end else if (!sirq.line) begin
      if (low_run_reg != `SIRQ_RUN_MAX) begin
        low_run_reg <= low_run_reg + 1'b1;                // [R18]
      end
    end else begin
      low_run_reg <= '0;
    end
  end

  // a run of one is a slot sample; two or three is a stop; four up starts
  assign run_end    = sirq.line && (low_run_reg != '0);
  assign start_seen = run_end && (low_run_reg >= `SIRQ_START_MIN); // [R01]
  assign stop_seen  = run_end &&
                      ((low_run_reg == `SIRQ_STOP_QUIET) ||
                       (low_run_reg == `SIRQ_STOP_CONT));         // [R12]

  // quiet start only from an idle, high line with a changed request
  assign qstart_ok  = quiet_reg && sirq.line && (low_run_reg == '0) &&
                      (pending != reported_reg);                  // [R19]

  // ----------------------------------------------------------------------
  // frame sequencer, next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    frame_next = frame_reg;
    if (start_seen) begin
      // the high clock after the pulse is recovery; next is turnaround
      state_next = SIRQ_D_LEAD;                           // [R01] [R14]
      phase_next = SIRQ_PH_T;
      frame_next = '0;
    end else begin
      unique case (state_reg)
        SIRQ_D_IDLE: begin
          if (qstart_ok) begin
            state_next = SIRQ_D_QSTART;                   // [R15]
          end
        end
        SIRQ_D_QSTART: begin
          state_next = SIRQ_D_IDLE;                       // [R15]
        end
        SIRQ_D_LEAD: begin
          state_next = SIRQ_D_FRAME;                      // [R06]
          phase_next = SIRQ_PH_S;
        end
        SIRQ_D_FRAME: begin
          if (stop_seen) begin
            state_next = SIRQ_D_IDLE;                     // [R10] [R13]
          end else begin
            unique case (phase_reg)
              SIRQ_PH_S: phase_next = SIRQ_PH_R;          // [R02]
              SIRQ_PH_R: phase_next = SIRQ_PH_T;          // [R02]
              SIRQ_PH_T: begin
                if (frame_reg == `SIRQ_LAST_FRAME) begin
                  state_next = SIRQ_D_TAIL;               // [R08]
                end else begin
                  phase_next = SIRQ_PH_S;                 // [R02] [R07]
                  frame_next = frame_reg + 1'b1;
                end
              end
            endcase
          end
        end
        SIRQ_D_TAIL: begin
          if (stop_seen) begin
            state_next = SIRQ_D_IDLE;                     // [R10] [R13]
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // frame sequencer, state registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SIRQ_D_IDLE;
      phase_reg <= SIRQ_PH_T;
      frame_reg <= '0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      frame_reg <= frame_next;
    end
  end

  // ----------------------------------------------------------------------
  // line drive for the coming clock
  // ----------------------------------------------------------------------
  // never drives during host start, or during stop unless the host ends before frame 32 with the next slot pending; released by default
  always_comb begin
    oe_next  = 1'b0;                                      // [R05] [R11]
    drv_next = 1'b1;
    if (state_next == SIRQ_D_QSTART) begin
      oe_next  = 1'b1;                                    // [R15]
      drv_next = 1'b0;
    end else if (state_next == SIRQ_D_FRAME) begin
      unique case (phase_next)
        SIRQ_PH_S: begin
          oe_next  = pending[frame_next];                 // [R03] [R17]
          drv_next = 1'b0;
        end
        SIRQ_PH_R: begin
          oe_next  = oe_reg && !drv_reg;                  // [R04] [R17]
          drv_next = 1'b1;
        end
        SIRQ_PH_T: begin
          oe_next  = 1'b0;                                // [R05]
          drv_next = 1'b1;
        end
      endcase
    end
  end

  // drive registers launched on the rising edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_reg  <= 1'b0;
      drv_reg <= 1'b1;
    end else begin
      oe_reg  <= oe_next;                                 // [R06]
      drv_reg <= drv_next;
    end
  end

  assign sirq.dev_oe  = oe_reg;
  assign sirq.dev_drv = drv_reg;

  // ----------------------------------------------------------------------
  // last reported request per slot
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reported_reg <= '0;
    end else if ((state_next == SIRQ_D_FRAME) &&
                 (phase_next == SIRQ_PH_S)) begin
      reported_reg[frame_next] <= pending[frame_next];    // [R19]
    end
  end

  // ----------------------------------------------------------------------
  // sample mode, decoded from the stop length
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet_reg <= 1'b0;                                  // [R16]
    end else if (stop_seen && ((state_reg == SIRQ_D_FRAME) ||
                               (state_reg == SIRQ_D_TAIL))) begin
      quiet_reg <= (low_run_reg == `SIRQ_STOP_QUIET);     // [R12]
    end
  end

  // ----------------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet_mode_o <= 1'b0;
      frame_busy_o <= 1'b0;
    end else begin
      quiet_mode_o <= quiet_reg;
      frame_busy_o <= (state_next == SIRQ_D_LEAD) ||
                      (state_next == SIRQ_D_FRAME) ||
                      (state_next == SIRQ_D_TAIL);
    end
  end

endmodule

//--- hdl/sirq_host.sv
// sirq_host.sv: host end of the serial irq link (start/stop and sampling)
// assumes: line on clk_i (pci clock) with a pull-up; user inputs on clk_i
`timescale 1ns/100ps
`include "sirq_defs.svh"

module sirq_host
  import sirq_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  sirq_if.host                          sirq,
  input  wire logic                     poll_i,
  input  wire logic [3:0]               start_len_i,
  input  wire logic [5:0]               frames_i,
  input  wire logic                     quiet_next_i,
  output logic      [`SIRQ_FRAMES-1:0]  irq_state_o,
  output logic                          cycle_done_o,
  output logic                          quiet_mode_o
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  sirq_host_state_e          state_reg;
  sirq_phase_e               phase_reg;
  logic [`SIRQ_FRAME_W-1:0]  frame_reg;
  logic [3:0]                cnt_reg;
  logic [3:0]                len_reg;
  logic [5:0]                nfr_reg;
  logic                      qnext_reg;
  logic [3:0]                len_clamp;

  // start pulse kept inside four to eight clocks
  assign len_clamp = (start_len_i < `SIRQ_START_MIN) ? `SIRQ_START_MIN :
                     (start_len_i > `SIRQ_START_MAX) ? `SIRQ_START_MAX :
                     start_len_i;                         // [R16]

  // ----------------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SIRQ_H_IDLE;
      phase_reg <= SIRQ_PH_T;
      frame_reg <= '0;
      cnt_reg   <= '0;
      len_reg   <= `SIRQ_START_MIN;
      nfr_reg   <= 6'h20;
      qnext_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        SIRQ_H_IDLE: begin
          // a slave low clock in quiet mode counts as the first low
          if (poll_i || (quiet_mode_o && !sirq.line)) begin
            state_reg <= SIRQ_H_START;                    // [R15] [R16]
            cnt_reg   <= (!sirq.line) ? 4'h2 : 4'h1;
            len_reg   <= len_clamp;
            nfr_reg   <= (frames_i == '0) ? 6'h01 :
                         (frames_i > 6'h20) ? 6'h20 : frames_i;
            qnext_reg <= quiet_next_i;
          end
        end
        SIRQ_H_START: begin
          if (cnt_reg >= len_reg) begin
            state_reg <= SIRQ_H_SREC;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        SIRQ_H_SREC: state_reg <= SIRQ_H_STA;
        SIRQ_H_STA: begin
          state_reg <= SIRQ_H_FRAME;                      // [R01]
          phase_reg <= SIRQ_PH_S;
          frame_reg <= '0;
        end
        SIRQ_H_FRAME: begin
          unique case (phase_reg)
            SIRQ_PH_S: phase_reg <= SIRQ_PH_R;            // [R02]
            SIRQ_PH_R: phase_reg <= SIRQ_PH_T;
            SIRQ_PH_T: begin
              if ({1'b0, frame_reg} == nfr_reg - 6'h01) begin
                state_reg <= SIRQ_H_STOP;                 // [R10]
                cnt_reg   <= 4'h1;
              end else begin
                phase_reg <= SIRQ_PH_S;                   // [R07]
                frame_reg <= frame_reg + 1'b1;
              end
            end
          endcase
        end
        SIRQ_H_STOP: begin
          if (cnt_reg >= (qnext_reg ? `SIRQ_STOP_QUIET
                                    : `SIRQ_STOP_CONT)) begin
            state_reg <= SIRQ_H_PREC;                     // [R11] [R12]
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        SIRQ_H_PREC: state_reg <= SIRQ_H_PTA;
        SIRQ_H_PTA:  state_reg <= SIRQ_H_IDLE;            // [R14]
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // line drive: low in pulses, one high clock, then release
  // ----------------------------------------------------------------------
  assign sirq.host_oe  = (state_reg == SIRQ_H_START) ||
                         (state_reg == SIRQ_H_SREC)  ||
                         (state_reg == SIRQ_H_STOP)  ||
                         (state_reg == SIRQ_H_PREC);      // [R17]
  assign sirq.host_drv = (state_reg == SIRQ_H_SREC) ||
                         (state_reg == SIRQ_H_PREC);

  // ----------------------------------------------------------------------
  // slot sampling and cycle status
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_state_o  <= '0;
      cycle_done_o <= 1'b0;
      quiet_mode_o <= 1'b0;                               // [R16]
    end else begin
      cycle_done_o <= (state_reg == SIRQ_H_PTA);
      if ((state_reg == SIRQ_H_FRAME) && (phase_reg == SIRQ_PH_S)) begin
        irq_state_o[frame_reg] <= !sirq.line;             // [R03] [R18]
      end
      if (state_reg == SIRQ_H_PTA) begin
        quiet_mode_o <= qnext_reg;                        // [R12]
      end
    end
  end

endmodule

//--- verification/sirq_link_properties.sv
// sirq_link_properties.sv: timing checks on the shared serial irq line
// assumes: instanced in tb beside the interface, one clock, async reset
`timescale 1ns/100ps
module sirq_link_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic dev_drv,
  input wire logic dev_oe,
  input wire logic host_drv,
  input wire logic host_oe,
  input wire logic line
);
  logic [6:0] pos_reg;
  logic [3:0] low_reg;
  logic [3:0] hrun_reg;
  logic       act_reg;
  wire        dev_low  = dev_oe & ~dev_drv;
  wire        dev_high = dev_oe & dev_drv;
  wire        host_low = host_oe & ~host_drv;

  // ----------------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------------
  // clocks since a start pulse ended, and frames active flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_reg <= 7'h7F;
      act_reg <= 1'b0;
    end else if (line && low_reg >= 4'h4) begin
      pos_reg <= 7'h01;
      act_reg <= 1'b1;
    end else begin
      pos_reg <= (pos_reg == 7'h7F) ? pos_reg : pos_reg + 7'h01;
      if (line && (low_reg == 4'h2 || low_reg == 4'h3))
        act_reg <= 1'b0;
    end
  end

  // length of line low run and host low run
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_reg  <= 4'h0;
      hrun_reg <= 4'h0;
    end else begin
      low_reg  <= line ? 4'h0 : low_reg + {3'h0, low_reg != 4'hF};
      hrun_reg <= host_low ? hrun_reg + 4'h1 : 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_host_low_end;
    host_low ##1 !host_low;
  endsequence
  sequence s_host_release;
    (host_oe && host_drv) ##1 !host_oe;
  endsequence

  a_host_high_release: assert property (
    s_host_low_end |-> s_host_release)
    else $error("host low run not closed by one high clock");
  a_host_run_len: assert property (s_host_low_end |->
    (hrun_reg >= 4'h2 && hrun_reg <= 4'h8))
    else $error("host low run length out of range");
  a_quiet_takeover: assert property (
    dev_low && !act_reg && !host_oe |=> host_low)
    else $error("host did not take over quiet start");
  a_dev_slot_phase: assert property (dev_low && act_reg |->
    (pos_reg % 7'd3 == 7'd2 && pos_reg <= 7'd95))
    else $error("device drove low outside a sample clock");
  a_dev_recovery_high: assert property (
    dev_low && act_reg |=> dev_high)
    else $error("device did not drive recovery high");
  a_dev_turn_release: assert property (dev_high |=> !dev_oe)
    else $error("device held line in turnaround");
  a_dev_quiet_single: assert property (
    dev_low && !act_reg |=> !dev_oe)
    else $error("device quiet start longer than one clock");
  a_no_fight: assert property (!(dev_high && host_low))
    else $error("device drove high against host low");
endmodule

//--- verification/tb.sv
// tb.sv: random and corner serial irq cycles across both link ends
// assumes: design files compiled first; 250 MHz pci clock
`timescale 1ns/100ps
`include "sirq_defs.svh"
module tb;
  logic                    clk_i        = 1'b0;
  logic                    rst_n_i      = 1'b0;
  logic [7:0]              req          = 8'h00;
  logic                    poll_i       = 1'b0;
  logic [3:0]              start_len_i  = 4'h4;
  logic [5:0]              frames_i     = 6'h0D;
  logic                    quiet_next_i = 1'b0;
  logic [`SIRQ_FRAMES-1:0] irq_state_o;
  logic                    cycle_done_o;
  logic                    host_quiet;
  logic                    dev_quiet;
  logic                    frame_busy;
  logic                    busy_seen;
  logic [31:0]             rng          = 32'd62315;
  logic [31:0]             rn;
  int                      fail_count   = 0;
  int                      comparisons  = 0;

  // ----------------------------------------------------------------------
  // clock, link and both ends
  // ----------------------------------------------------------------------
  always #2 clk_i = ~clk_i;
  sirq_if link ();
  sirq_dev sirq_dev_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .sirq(link.dev),
    .kbd_irq_i(req[0]), .hwm_irq_i(req[1]), .smi_req_i(req[2]),
    .uartb_irq_i(req[3]), .uarta_irq_i(req[4]), .fdc_irq_i(req[5]),
    .lpt_irq_i(req[6]), .mouse_irq_i(req[7]), .quiet_mode_o(dev_quiet),
    .frame_busy_o(frame_busy));
  sirq_host sirq_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sirq(link.host), .poll_i(poll_i), .start_len_i(start_len_i),
    .frames_i(frames_i), .quiet_next_i(quiet_next_i),
    .irq_state_o(irq_state_o), .cycle_done_o(cycle_done_o),
    .quiet_mode_o(host_quiet));
  sirq_link_properties sirq_link_properties_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .dev_drv(link.dev_drv), .dev_oe(link.dev_oe),
    .host_drv(link.host_drv), .host_oe(link.host_oe), .line(link.line));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // xorshift source
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // slot bits of the device sources, index is frame minus one
  function automatic logic [31:0] exp_state(logic [7:0] r);
    logic [31:0] s;
    s = 32'h0000_0000;
    s[1] = r[0];
    s[2] = r[1] | r[2];
    s[3] = r[3];
    s[4] = r[4];
    s[6] = r[5];
    s[7] = r[6];
    s[12] = r[7];
    return s;
  endfunction

  function automatic int len_c(logic [3:0] l);
    return (l < 4'h4) ? 4 : (l > 4'h8) ? 8 : int'(l);
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // wait for cycle end, measure clocks and the first low run
  task automatic wait_done(output int n, output int run);
    bit ended;
    n = 0;
    run = 0;
    ended = 1'b0;
    busy_seen = 1'b0;
    do begin
      @(posedge clk_i);
      poll_i <= 1'b0;
      #1;
      n++;
      busy_seen = busy_seen | frame_busy;
      if (!ended && link.line === 1'b0)
        run++;
      else if (run > 0)
        ended = 1'b1;
    end while (cycle_done_o !== 1'b1 && n < 400);
  endtask

  // results common to every cycle
  task automatic after_cycle(logic qn, int run);
    check("done", cycle_done_o, 1'b1);
    check("start run", run, len_c(start_len_i));
    check("irq state", irq_state_o, exp_state(req));
    check("busy seen", busy_seen, 1'b1);
    check("host mode", host_quiet, qn);
    check("dev mode", dev_quiet, qn);
    check("busy", frame_busy, 1'b0);
    check("idle line", link.line, 1'b1);
    $display("cycle done frames %0d quiet %0d", frames_i, qn);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // host-started cycle with fresh requests
  task automatic poll_cycle(logic [3:0] len, logic [5:0] f, logic qn);
    int n;
    int run;
    rn = xs();
    @(posedge clk_i);
    req <= rn[7:0];
    start_len_i <= len;
    frames_i <= f;
    quiet_next_i <= qn;
    poll_i <= 1'b1;
    wait_done(n, run);
    check("cycle clocks", n, len_c(len) + 3 * f + (qn ? 7 : 8));
    after_cycle(qn, run);
  endtask

  // quiet mode: silence while unchanged, then a device start
  task automatic quiet_cycle(logic [5:0] f, logic qn);
    int n;
    int run;
    rn = xs();
    rn[0] = ~req[0];
    repeat (30) begin
      @(posedge clk_i);
      #1;
      check("quiet idle", link.line, 1'b1);
    end
    @(posedge clk_i);
    req <= rn[7:0];
    frames_i <= f;
    quiet_next_i <= qn;
    wait_done(n, run);
    after_cycle(qn, run);
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check("reset mode", {host_quiet, dev_quiet, link.line}, 3'h1);
    poll_cycle(4'h4, 6'd13, 1'b0);
    poll_cycle(4'h8, 6'd32, 1'b1);
    quiet_cycle(6'd17, 1'b1);
    poll_cycle(4'h0, 6'd17, 1'b0);
    for (int i = 0; i < 24; i++) begin
      rn = xs();
      if (host_quiet)
        quiet_cycle(6'd13 + 6'(rn[5:0] % 20), rn[8]);
      else
        poll_cycle(rn[12:9], 6'd13 + 6'(rn[5:0] % 20), rn[8]);
    end
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    check("mode after reset", {host_quiet, dev_quiet}, 2'h0);
    poll_cycle(4'hF, 6'd21, 1'b0);
    conclude();
  end

  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    conclude();
  end
endmodule
